/* design/ufc_top.sv */
// Dual UART channel: FIFOs, trigger levels, baud divisor, loopback, RTS/CTS flow control
//
// Functional notes
// RL1 - Modem control RTS bit set drives request-to-send pin low.
// RL2 - Request-to-send pin is high after every reset.
// RL3 - Flow logic steers request-to-send only when auto-RTS bit 6 is set.
// RL4 - Loopback ignores the receive pin and feeds transmit data to the receiver.
// RL5 - Receive and transmit FIFOs each hold 64 characters in FIFO mode.
// RL6 - Each receive entry keeps three error bits with its character.
// RL7 - Baud generator divides the reference clock by 1 to 65535.
// RL8 - FIFOs disabled after reset; trigger level then one character.
// RL9 - Separate receive and transmit trigger levels, preset or programmable.
// RL10 - Zero programmable trigger register selects preset, nonzero selects programmable.
// RL11 - Auto-CTS bit 7 and auto-RTS bit 6 enable independently.
// RL12 - With auto-CTS, no character starts unless clear-to-send is active.
// RL13 - Auto-RTS asserts while receive FIFO has room, drops when full enough.
// RL14 - Threshold register halt and resume levels steer auto-RTS.
// RL15 - All-zero threshold register falls back to preset trigger levels.
// RL16 - Looped RTS to peer CTS means no send without receive space.
// RL17 - Status reads never disturb transmission or reception.
// RL18 - Auto-RTS drops at halt level bits 3:0, returns at resume bits 7:4.
// RL19 - Peer drops clear-to-send before mid last stop bit to stop next character.
// RL20 - Clear-to-send changes raise no host event under automatic flow control.
// RL21 - Both channels have independent FIFOs, settings and flow lines.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.svh"
module ufc_top #(
  parameter int DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic chan_a_serial_in,
  input wire logic chan_b_serial_in,
  output logic chan_a_serial_out,
  output logic chan_b_serial_out,
  input wire logic chan_a_clear_to_send_n,
  input wire logic chan_b_clear_to_send_n,
  output logic chan_a_request_to_send_n,
  output logic chan_b_request_to_send_n
);
  wire logic [1:0] rx_pin;
  wire logic [1:0] cts_pin_n;
  wire logic [1:0] ser_out;
  wire logic [1:0] rts_out_n;
  wire logic [7:0] ch_rdata [2];

  assign rx_pin = {chan_b_serial_in, chan_a_serial_in};
  assign cts_pin_n = {chan_b_clear_to_send_n, chan_a_clear_to_send_n};
  assign chan_a_serial_out = ser_out[0];
  assign chan_b_serial_out = ser_out[1];
  assign chan_a_request_to_send_n = rts_out_n[0];
  assign chan_b_request_to_send_n = rts_out_n[1];

  // Preset trigger level from a two-bit selection
  function automatic logic [6:0] ufc_preset(input logic [1:0] sel, input logic is_rx);
    case (sel)
      2'h0: ufc_preset = `UFC_TRIG_0;
      2'h1: ufc_preset = `UFC_TRIG_1;
      2'h2: ufc_preset = is_rx ? `UFC_RX_TRIG_2 : `UFC_TX_TRIG_2;
      default: ufc_preset = is_rx ? `UFC_RX_TRIG_3 : `UFC_TX_TRIG_3;
    endcase
  endfunction

  // Effective trigger: one char without FIFO, else programmable nibble x4 or preset
  function automatic logic [6:0] ufc_level(input logic en, input logic [3:0] nib,
                                           input logic [1:0] sel, input logic is_rx);
    if (!en) begin
      ufc_level = `UFC_HOLD_DEPTH; // RL8
    end else if (nib != 4'h0) begin
      ufc_level = {1'b0, nib, 2'b00}; // RL10
    end else begin
      ufc_level = ufc_preset(sel, is_rx); // RL9
    end
  endfunction

  // Each channel is a full copy; nothing but the read mux is shared
  for (genvar g = 0; g < 2; g++) begin : gen_chan // RL21
    localparam logic CH = 1'(g);
    logic hit_wr;
    logic hit_rd;
    logic [7:0] fctl;
    logic [7:0] mctl;
    logic [7:0] efc;
    logic [7:0] ftc;
    logic [7:0] ptl;
    logic [15:0] divisor;
    logic rx_s1;
    logic rx_s2;
    logic cts_s1;
    logic cts_s2;
    logic cts_prev;
    logic [15:0] bcnt;
    logic tick;
    logic [6:0] cap;
    logic [6:0] rx_trig;
    logic [6:0] tx_trig;
    logic [6:0] halt_lvl;
    logic [6:0] resume_lvl;
    logic rx_clr;
    logic tx_clr;
    logic rx_push;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic [10:0] rx_din;
    logic [10:0] rx_dout;
    logic [7:0] tx_dout;
    logic [6:0] rx_lvl;
    logic [6:0] tx_lvl;
    logic rx_src;
    logic cts_ok;
    logic tx_line;
    logic tx_pin;
    logic [8:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_os;
    ufc_pkg::ufc_tx_state_t tx_state;
    ufc_pkg::ufc_rx_state_t rx_state;
    logic [7:0] rx_shift;
    logic [3:0] rx_bits;
    logic [3:0] rx_os;
    logic overrun;
    logic dcts;
    logic flow_ok;
    logic rts_n;
    logic [7:0] rdata;

    assign hit_wr = reg_wr && (reg_addr[4] == CH);
    assign hit_rd = reg_rd && (reg_addr[4] == CH);

    // Software-visible control registers
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        fctl <= `UFC_CTRL_RST; // RL8
        mctl <= `UFC_CTRL_RST;
        efc <= `UFC_CTRL_RST;
        ftc <= `UFC_CTRL_RST;
        ptl <= `UFC_CTRL_RST;
        divisor <= `UFC_DIV_RST;
      end else if (hit_wr) begin
        case (reg_addr[3:0])
          `UFC_REG_FCTL: fctl <= reg_wdata & 8'hf1; // Clear bits self-clear
          `UFC_REG_MCTL: mctl <= reg_wdata;
          `UFC_REG_EFC: efc <= reg_wdata; // RL11
          `UFC_REG_FTC: ftc <= reg_wdata;
          `UFC_REG_PTL: ptl <= reg_wdata;
          `UFC_REG_DIVL: divisor[7:0] <= reg_wdata;
          `UFC_REG_DIVH: divisor[15:8] <= reg_wdata;
          default: ;
        endcase
      end
    end

    // Pin synchronisers; only the second stage is used by logic
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        rx_s1 <= 1'b1;
        rx_s2 <= 1'b1;
      end else begin
        rx_s1 <= rx_pin[g];
        rx_s2 <= rx_s1;
      end
    end

    // CTS chain runs through reset, so an active pin gives no false change at release
    always_ff @(posedge ref_clk) begin
      cts_s1 <= cts_pin_n[g];
      cts_s2 <= cts_s1;
      cts_prev <= cts_s2;
    end

    // Baud tick at 16x bit rate; divisor zero stops the generator
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        bcnt <= 16'h0000;
        tick <= 1'b0;
      end else if (divisor == 16'h0000) begin
        bcnt <= 16'h0000;
        tick <= 1'b0;
      end else if (bcnt >= divisor - 16'h0001) begin // RL7
        bcnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        bcnt <= bcnt + 16'h0001;
        tick <= 1'b0;
      end
    end

    // Levels: capacity, triggers, flow thresholds
    assign cap = fctl[`UFC_FCTL_EN] ? `UFC_FIFO_DEPTH : `UFC_HOLD_DEPTH; // RL5
    assign rx_trig = ufc_level(fctl[`UFC_FCTL_EN], ptl[7:4], fctl[7:6], 1'b1); // RL9
    assign tx_trig = ufc_level(fctl[`UFC_FCTL_EN], ptl[3:0], fctl[5:4], 1'b0); // RL9
    assign halt_lvl = (ftc == 8'h00) ? rx_trig : {1'b0, ftc[3:0], 2'b00}; // RL15 RL18
    assign resume_lvl = (ftc != 8'h00) ? {1'b0, ftc[7:4], 2'b00} : // RL18
                        (fctl[7:6] == 2'h0) ? 7'h00 :
                        ufc_preset(fctl[7:6] - 2'h1, 1'b1); // RL15

    // FIFO strobes; only a data read pops, status reads have no side effect
    assign rx_clr = hit_wr && (reg_addr[3:0] == `UFC_REG_FCTL) && reg_wdata[`UFC_FCTL_RXCLR];
    assign tx_clr = hit_wr && (reg_addr[3:0] == `UFC_REG_FCTL) && reg_wdata[`UFC_FCTL_TXCLR];
    assign rx_pop = hit_rd && (reg_addr[3:0] == `UFC_REG_DATA) && (rx_lvl != 7'h00); // RL17
    assign tx_push = hit_wr && (reg_addr[3:0] == `UFC_REG_DATA) && (tx_lvl < cap);
    assign rx_push = (rx_state == ufc_pkg::RX_STOP) && tick && (rx_os == `UFC_OVS_LAST) &&
                     (rx_lvl < cap);
    // Break and framing travel with the character; the parity bit is stored as zero
    assign rx_din = {(rx_s2 == 1'b0) && (rx_shift == 8'h00) && !mctl[`UFC_MCTL_LOOP] ||
                     (rx_src == 1'b0) && (rx_shift == 8'h00),
                     !rx_src, 1'b0, rx_shift}; // RL6

    ufc_fifo #(.WIDTH(11), .DEPTH(DEPTH), .LW(7)) u_rx_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clear(rx_clr),
      .push(rx_push),
      .din(rx_din),
      .pop(rx_pop),
      .dout(rx_dout),
      .level(rx_lvl)
    );

    ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LW(7)) u_tx_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clear(tx_clr),
      .push(tx_push),
      .din(reg_wdata),
      .pop(tx_pop),
      .dout(tx_dout),
      .level(tx_lvl)
    );

    // Transmit start gate: CTS checked only before each new character
    assign cts_ok = !efc[`UFC_EFC_ACTS] || !cts_s2; // RL12 RL16
    assign tx_pop = (tx_state == ufc_pkg::TX_IDLE) && tick && (tx_lvl != 7'h00) && cts_ok; // RL12

    // Transmitter: start, eight data bits LSB first, one stop bit
    always_ff @(posedge ref_clk) begin
      if (!rst_b || tx_clr) begin
        tx_state <= ufc_pkg::TX_IDLE;
        tx_line <= 1'b1;
        tx_shift <= 9'h1ff;
        tx_bits <= 4'h0;
        tx_os <= 4'h0;
      end else begin
        case (tx_state)
          ufc_pkg::TX_IDLE: begin
            if (tx_pop) begin
              tx_line <= 1'b0;
              tx_shift <= {1'b1, tx_dout};
              tx_bits <= 4'h0;
              tx_os <= 4'h0;
              tx_state <= ufc_pkg::TX_SEND;
            end
          end
          ufc_pkg::TX_SEND: begin
            if (tick) begin
              tx_os <= tx_os + 4'h1;
              if (tx_os == `UFC_OVS_LAST) begin
                if (tx_bits == `UFC_TX_LAST_BIT) begin
                  tx_state <= ufc_pkg::TX_IDLE;
                end else begin
                  tx_line <= tx_shift[0];
                  tx_shift <= {1'b1, tx_shift[8:1]};
                  tx_bits <= tx_bits + 4'h1;
                end
              end
            end
          end
          default: tx_state <= ufc_pkg::TX_IDLE;
        endcase
      end
    end

    // Loopback holds the pin idle and feeds the receiver internally
    assign rx_src = mctl[`UFC_MCTL_LOOP] ? tx_line : rx_s2; // RL4

    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        tx_pin <= 1'b1;
      end else begin
        tx_pin <= mctl[`UFC_MCTL_LOOP] ? 1'b1 : tx_line; // RL4
      end
    end
    assign ser_out[g] = tx_pin;

    // Receiver: start verified at mid-bit, data sampled every 16 ticks
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        rx_state <= ufc_pkg::RX_IDLE;
        rx_shift <= 8'h00;
        rx_bits <= 4'h0;
        rx_os <= 4'h0;
      end else if (tick) begin
        case (rx_state)
          ufc_pkg::RX_IDLE: begin
            rx_os <= 4'h0;
            if (!rx_src) begin
              rx_state <= ufc_pkg::RX_START;
            end
          end
          ufc_pkg::RX_START: begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == `UFC_OVS_MID) begin
              rx_os <= 4'h0;
              rx_bits <= 4'h0;
              rx_state <= rx_src ? ufc_pkg::RX_IDLE : ufc_pkg::RX_DATA; // Glitch filter
            end
          end
          ufc_pkg::RX_DATA: begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == `UFC_OVS_LAST) begin
              rx_shift <= {rx_src, rx_shift[7:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == `UFC_RX_LAST_BIT) begin
                rx_state <= ufc_pkg::RX_STOP;
              end
            end
          end
          ufc_pkg::RX_STOP: begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == `UFC_OVS_LAST) begin
              rx_state <= ufc_pkg::RX_IDLE;
            end
          end
          default: rx_state <= ufc_pkg::RX_IDLE;
        endcase
      end
    end

    // Sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        overrun <= 1'b0;
        dcts <= 1'b0;
      end else begin
        if (rx_state == ufc_pkg::RX_STOP && tick && rx_os == `UFC_OVS_LAST && rx_lvl >= cap) begin
          overrun <= 1'b1; // Character dropped, FIFO kept intact
        end else if (hit_wr && reg_addr[3:0] == `UFC_REG_LSTAT && reg_wdata[`UFC_LSTAT_OVR]) begin
          overrun <= 1'b0;
        end
        if (cts_s2 != cts_prev && !efc[`UFC_EFC_ACTS] && !efc[`UFC_EFC_ARTS]) begin
          dcts <= 1'b1; // RL20
        end else if (hit_wr && reg_addr[3:0] == `UFC_REG_FSTAT && reg_wdata[`UFC_FSTAT_DCTS]) begin
          dcts <= 1'b0;
        end
      end
    end

    // Auto-RTS hysteresis: halt at or above halt level, resume at or below resume level
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        flow_ok <= 1'b1;
      end else if (rx_lvl >= halt_lvl) begin
        flow_ok <= 1'b0; // RL13 RL14
      end else if (rx_lvl <= resume_lvl) begin
        flow_ok <= 1'b1; // RL13 RL14
      end
    end

    // RTS pin: manual bit unless auto-RTS owns it
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        rts_n <= 1'b1; // RL2
      end else if (efc[`UFC_EFC_ARTS]) begin
        rts_n <= !flow_ok; // RL3 RL16
      end else begin
        rts_n <= !mctl[`UFC_MCTL_RTS]; // RL1
      end
    end
    assign rts_out_n[g] = rts_n;

    // Read mux; status reads are pure observation
    always_comb begin
      rdata = 8'h00;
      case (reg_addr[3:0])
        `UFC_REG_DATA: rdata = rx_dout[7:0];
        `UFC_REG_FCTL: rdata = fctl;
        `UFC_REG_MCTL: rdata = mctl;
        `UFC_REG_EFC: rdata = efc;
        `UFC_REG_FTC: rdata = ftc;
        `UFC_REG_PTL: rdata = ptl;
        `UFC_REG_DIVL: rdata = divisor[7:0];
        `UFC_REG_DIVH: rdata = divisor[15:8];
        `UFC_REG_LSTAT: rdata = {rx_lvl >= rx_trig,
                                 tx_lvl == 7'h00 && tx_state == ufc_pkg::TX_IDLE,
                                 tx_lvl == 7'h00,
                                 rx_dout[10:8] & {3{rx_lvl != 7'h00}},
                                 overrun, rx_lvl != 7'h00}; // RL17
        `UFC_REG_RXLVL: rdata = {1'b0, rx_lvl};
        `UFC_REG_TXLVL: rdata = {1'b0, tx_lvl};
        `UFC_REG_FSTAT: rdata = {4'h0, (cap - tx_lvl) >= tx_trig, !rts_n, dcts, !cts_s2};
        default: rdata = 8'h00;
      endcase
    end
    assign ch_rdata[g] = rdata;
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= ch_rdata[reg_addr[4]];
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // ufc_top
`default_nettype wire

/* design/ufc_map.svh */
// Register offsets, field positions, reset values and levels of the UART channel block
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

// Register indices within one channel (address bit 4 picks the channel)
`define UFC_REG_DATA 4'h0
`define UFC_REG_FCTL 4'h1
`define UFC_REG_MCTL 4'h2
`define UFC_REG_EFC 4'h3
`define UFC_REG_FTC 4'h4
`define UFC_REG_PTL 4'h5
`define UFC_REG_DIVL 4'h6
`define UFC_REG_DIVH 4'h7
`define UFC_REG_LSTAT 4'h8
`define UFC_REG_RXLVL 4'h9
`define UFC_REG_TXLVL 4'ha
`define UFC_REG_FSTAT 4'hb

// Field positions
`define UFC_FCTL_EN 0
`define UFC_FCTL_RXCLR 1
`define UFC_FCTL_TXCLR 2
`define UFC_MCTL_RTS 1
`define UFC_MCTL_LOOP 4
`define UFC_EFC_ARTS 6
`define UFC_EFC_ACTS 7
`define UFC_FSTAT_DCTS 1
`define UFC_LSTAT_OVR 1

// Reset values
`define UFC_CTRL_RST 8'h00
`define UFC_DIV_RST 16'h0001

// Levels, in characters
`define UFC_FIFO_DEPTH 7'h40
`define UFC_HOLD_DEPTH 7'h01
`define UFC_TRIG_0 7'h08
`define UFC_TRIG_1 7'h10
`define UFC_RX_TRIG_2 7'h38
`define UFC_RX_TRIG_3 7'h3c
`define UFC_TX_TRIG_2 7'h20
`define UFC_TX_TRIG_3 7'h38

// Oversampling: last tick of a bit and mid-bit tick; last transmit and receive bit counts
`define UFC_OVS_LAST 4'hf
`define UFC_OVS_MID 4'h7
`define UFC_TX_LAST_BIT 4'h9
`define UFC_RX_LAST_BIT 4'h7

`endif

/* design/ufc_pkg.sv */
// Types shared by the UART channel block
package ufc_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} ufc_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufc_rx_state_t;
endpackage

/* design/ufc_fifo.sv */
// Synchronous FIFO with level count, used for receive and transmit characters
`timescale 1ns/1ps
`default_nettype none
module ufc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 64,
  parameter int LW = 7
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  input wire logic pop,
  output logic [WIDTH-1:0] dout,
  output logic [LW-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push_ok;
  logic pop_ok;

  // Full and empty guards so a careless caller cannot corrupt the pointers
  assign push_ok = push && (level != LW'(DEPTH));
  assign pop_ok = pop && (level != '0);
  assign dout = mem[rd_ptr];

  // Storage has no reset; only pointers define content
  always_ff @(posedge ref_clk) begin
    if (push_ok) begin
      mem[wr_ptr] <= din;
    end
  end

  // Pointers and level
  always_ff @(posedge ref_clk) begin
    if (!rst_b || clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push_ok && !pop_ok) begin
        level <= level + 1'b1;
      end else if (pop_ok && !push_ok) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // ufc_fifo
`default_nettype wire

/* dv/ufc_top_assertions.sv */
// Port-level checks for the dual UART channel block
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.svh"
module ufc_top_assertions #(
  parameter int DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic chan_a_serial_in,
  input wire logic chan_b_serial_in,
  input wire logic chan_a_serial_out,
  input wire logic chan_b_serial_out,
  input wire logic chan_a_clear_to_send_n,
  input wire logic chan_b_clear_to_send_n,
  input wire logic chan_a_request_to_send_n,
  input wire logic chan_b_request_to_send_n
);
  logic [7:0] mctl_a, mctl_b, efc_a, efc_b, gap_cnt, frm_cnt;
  logic [2:0] blk_cnt;

  // Shadow controls, updated on the same edge as the block's own copies
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mctl_a <= 8'h00;
      mctl_b <= 8'h00;
      efc_a <= 8'h00;
      efc_b <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 5'h02) mctl_a <= reg_wdata;
      if (reg_addr == 5'h12) mctl_b <= reg_wdata;
      if (reg_addr == 5'h03) efc_a <= reg_wdata;
      if (reg_addr == 5'h13) efc_b <= reg_wdata;
    end
  end

  // Cycles since the last edge on the A pin; saturates so reset never looks like a short bit
  always_ff @(posedge ref_clk) begin
    if (!rst_b) gap_cnt <= 8'hff;
    else if ($changed(chan_a_serial_out)) gap_cnt <= 8'h00;
    else if (gap_cnt != 8'hff) gap_cnt <= gap_cnt + 8'h01;
  end

  // Cycles CTS has been off with auto-CTS on; four cover the two-flop synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !efc_a[`UFC_EFC_ACTS] || !chan_a_clear_to_send_n) blk_cnt <= 3'h0;
    else if (blk_cnt != 3'h7) blk_cnt <= blk_cnt + 3'h1;
  end

  // Cycles left in the frame at divisor 1, so data-bit falls never count as a start
  always_ff @(posedge ref_clk) begin
    if (!rst_b) frm_cnt <= 8'h00;
    else if (frm_cnt != 8'h00) frm_cnt <= frm_cnt - 8'h01;
    else if ($fell(chan_a_serial_out)) frm_cnt <= 8'h9f;
  end

  a_reset_idle: assert property (@(posedge ref_clk) !rst_b |=> chan_a_request_to_send_n &&
    chan_b_request_to_send_n && chan_a_serial_out && chan_b_serial_out)
    else $error("pins not idle after reset");
  a_rdata_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_level_max: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(reg_rd) && ($past(reg_addr[3:0]) inside {4'h9, 4'ha}) |-> reg_rdata <= 8'(DEPTH))
    else $error("fifo level above depth");
  a_rts_manual_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !efc_a[6] && !$past(efc_a[6]) && !$past(efc_a[6], 2) && $past(mctl_a[1]) == $past(mctl_a[1], 2)
    |-> chan_a_request_to_send_n == !$past(mctl_a[1]))
    else $error("channel a rts not following control bit");
  a_rts_manual_b: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !efc_b[6] && !$past(efc_b[6]) && !$past(efc_b[6], 2) && $past(mctl_b[1]) == $past(mctl_b[1], 2)
    |-> chan_b_request_to_send_n == !$past(mctl_b[1]))
    else $error("channel b rts not following control bit");
  a_loop_tx_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mctl_a[4] && $past(mctl_a[4], 3) |-> chan_a_serial_out)
    else $error("transmit pin active in loopback");
  a_bit_width: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(chan_a_serial_out) |-> gap_cnt >= 8'h0f)
    else $error("serial bit shorter than sixteen cycles");
  a_cts_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(chan_a_serial_out) && frm_cnt == 8'h00 |-> blk_cnt < 3'h4)
    else $error("character started while clear to send inactive");
endmodule // ufc_top_assertions

bind ufc_top ufc_top_assertions #(.DEPTH(DEPTH)) u_chk (.ref_clk, .rst_b, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .chan_a_serial_in, .chan_b_serial_in, .chan_a_serial_out,
  .chan_b_serial_out, .chan_a_clear_to_send_n, .chan_b_clear_to_send_n, .chan_a_request_to_send_n,
  .chan_b_request_to_send_n);
`default_nettype wire

/* dv/ufc_peer_model.sv */
// Remote serial peer: 8N1 sender and receiver with RTS/CTS handling
`timescale 1ns/1ps
`default_nettype none
module ufc_peer_model (
  input wire logic ref_clk,
  input wire logic tx_from_dut,
  input wire logic rts_n,
  output logic line,
  output logic cts_n
);
  int bit_cyc = 16;
  logic [7:0] rxq[$];

  // Idle line high; CTS starts active
  initial begin
    line = 1'h1;
    cts_n = 1'h0;
  end

  // One frame, LSB first; waits for rts_n low before the start bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    while (rts_n) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
  endtask

  // Mid-bit sampling keeps clear of the block's output edges
  always begin : rx_frame
    logic [7:0] b;
    @(negedge tx_from_dut);
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      b[i] = tx_from_dut;
    end
    repeat (bit_cyc) @(posedge ref_clk);
    rxq.push_back(b);
  end
endmodule // ufc_peer_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the dual UART channel block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, rst_b, reg_wr, reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic chan_a_serial_in, chan_b_serial_in, chan_a_serial_out, chan_b_serial_out;
  logic chan_a_clear_to_send_n, chan_b_clear_to_send_n, chan_a_request_to_send_n, chan_b_request_to_send_n;
  int fail_count = 0;
  int n_compared = 0;

  ufc_top #(.DEPTH(64)) u_dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .chan_a_serial_in, .chan_b_serial_in, .chan_a_serial_out, .chan_b_serial_out, .chan_a_clear_to_send_n,
    .chan_b_clear_to_send_n, .chan_a_request_to_send_n, .chan_b_request_to_send_n);
  ufc_peer_model u_pa (.ref_clk, .tx_from_dut(chan_a_serial_out), .rts_n(chan_a_request_to_send_n),
    .line(chan_a_serial_in), .cts_n(chan_a_clear_to_send_n));
  ufc_peer_model u_pb (.ref_clk, .tx_from_dut(chan_b_serial_out), .rts_n(chan_b_request_to_send_n),
    .line(chan_b_serial_in), .cts_n(chan_b_clear_to_send_n));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Gap cycle after each strobe so no signal is assigned twice in one step
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wait_pa(input int n);
    for (int i = 0; i < 600 && u_pa.rxq.size() < n; i++) @(posedge ref_clk);
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole sequence needs about 3k cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report;
  end

  initial begin
    rst_b = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    // Reset state of controls, divisor, status and pins
    rdc(5'h01, 8'h00);
    rdc(5'h02, 8'h00);
    rdc(5'h13, 8'h00);
    rdc(5'h06, 8'h01);
    rdc(5'h07, 8'h00);
    rdc(5'h08, 8'h60);
    rdc(5'h1f, 8'h00);
    chk({6'h0, chan_b_request_to_send_n, chan_a_request_to_send_n}, 8'h03);
    // Manual RTS on A only
    wr(5'h02, 8'h02);
    #1 chk({6'h0, chan_b_request_to_send_n, chan_a_request_to_send_n}, 8'h02);
    // One byte each way on A at divisor 1
    wr(5'h00, 8'ha5);
    u_pa.send(8'h69);
    wait_pa(1);
    chk(u_pa.rxq[0], 8'ha5);
    cyc(20);
    rdc(5'h09, 8'h01);
    rdc(5'h00, 8'h69);
    // Channel B at divisor 2, peer bit time doubled
    wr(5'h16, 8'h02);
    u_pb.bit_cyc = 32;
    wr(5'h10, 8'h5a);
    for (int i = 0; i < 900 && u_pb.rxq.size() < 1; i++) @(posedge ref_clk);
    chk(u_pb.rxq[0], 8'h5a);
    // Auto-CTS: CTS dropped mid-character holds the next one
    wr(5'h03, 8'h80);
    wr(5'h00, 8'h11);
    cyc(40);
    u_pa.cts_n <= 1'h1;
    wr(5'h00, 8'h22);
    cyc(300);
    rdc(5'h0a, 8'h01);
    chk(8'(u_pa.rxq.size()), 8'h02);
    chk(u_pa.rxq[1], 8'h11);
    #1 chk({7'h0, chan_a_request_to_send_n}, 8'h00);
    u_pa.cts_n <= 1'h0;
    wait_pa(3);
    chk(u_pa.rxq[2], 8'h22);
    rd(5'h0b, d);
    chk({7'h0, d[1]}, 8'h00);
    // Transmit FIFO refuses the 65th byte while CTS is off
    cyc(20);
    u_pa.cts_n <= 1'h1;
    wr(5'h01, 8'h01);
    for (int i = 0; i < 65; i++) wr(5'h00, 8'(i));
    rdc(5'h0a, 8'h40);
    wr(5'h01, 8'h05);
    rdc(5'h0a, 8'h00);
    u_pa.cts_n <= 1'h0;
    // Auto-RTS: halt at 4, resume at 0, manual bit still set
    wr(5'h04, 8'h01);
    wr(5'h03, 8'h40);
    #1 chk({7'h0, chan_a_request_to_send_n}, 8'h00);
    for (int i = 0; i < 4; i++) u_pa.send(8'h30 + 8'(i));
    cyc(20);
    #1 chk({7'h0, chan_a_request_to_send_n}, 8'h01);
    fork u_pa.send(8'h44); join_none
    cyc(300);
    rdc(5'h09, 8'h04);
    rdc(5'h08, 8'h61);
    wr(5'h05, 8'h10);
    rdc(5'h08, 8'he1);
    for (int i = 0; i < 3; i++) rdc(5'h00, 8'h30 + 8'(i));
    cyc(2);
    #1 chk({7'h0, chan_a_request_to_send_n}, 8'h01);
    rdc(5'h00, 8'h33);
    cyc(2);
    #1 chk({7'h0, chan_a_request_to_send_n}, 8'h00);
    cyc(300);
    rdc(5'h09, 8'h01);
    rdc(5'h00, 8'h44);
    // Loopback: pin traffic ignored, own byte returns, pin stays idle
    wr(5'h02, 8'h12);
    fork u_pa.send(8'h3c); join_none
    wr(5'h00, 8'hc3);
    cyc(300);
    rdc(5'h09, 8'h01);
    rdc(5'h00, 8'hc3);
    chk(8'(u_pa.rxq.size()), 8'h03);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
